// [rtl/sdci_bank.v]
// one bank: open row and its precharge timing
`timescale 1ns/1ps
`default_nettype none
`include "sdci_defines.vh"
module sdci_bank (
	input wire i_core_clk,
	input wire i_arst_n,
	input wire i_activate,
	input wire [`SDCI_ROW_W-1:0] i_row,
	input wire i_precharge,
	input wire i_flush,
	output wire o_open,
	output wire o_idle,
	output wire [`SDCI_ROW_W-1:0] o_row
);
	reg open_ff;
	reg [`SDCI_ROW_W-1:0] row_ff;
	reg [4:0] wait_ff;
	wire [31:0] pw_full = `SDCI_PRECHARGE_WAIT_CYC;
	assign o_open = open_ff;
	assign o_row = row_ff;
	assign o_idle = ~open_ff & (wait_ff == 5'h00);
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			open_ff <= 1'b0;
			row_ff <= {`SDCI_ROW_W{1'b0}};
			wait_ff <= 5'h00;
		end else if (i_flush) begin
			open_ff <= 1'b0;
			wait_ff <= 5'h00;
		end else if (i_precharge) begin
			// closed bank reopens only after the precharge wait
			open_ff <= 1'b0; // R11
			wait_ff <= pw_full[4:0];
		end else if (i_activate && o_idle) begin
			open_ff <= 1'b1; // R5
			row_ff <= i_row;
		end else if (wait_ff != 5'h00) begin
			wait_ff <= wait_ff - 5'h01;
		end
	end
endmodule // sdci_bank

// [rtl/sdci_defines.vh]
// constants for the sdram command interface
`ifndef SDCI_DEFINES_VH
`define SDCI_DEFINES_VH
`define SDCI_CLK_MHZ 200
`define SDCI_ROW_W 12
`define SDCI_COL_W 9
`define SDCI_ADDR_W 13
`define SDCI_DATA_W 32
`define SDCI_NBANK 4
`define SDCI_A10 10
`define SDCI_OPC_W 10
`define SDCI_BANK_EXT 2'b10
`define SDCI_MODE_RST 10'h020
`define SDCI_EXT_RST 10'h000
`define SDCI_CL_LSB 4
`define SDCI_BL_LSB 0
`define SDCI_WBS_BIT 9
`define SDCI_PRECHARGE_WAIT_NS 18
`define SDCI_PRECHARGE_WAIT_CYC ((`SDCI_PRECHARGE_WAIT_NS*`SDCI_CLK_MHZ+999)/1000)
`define SDCI_MODE_LOAD_WAIT_NS 12
`define SDCI_MODE_LOAD_WAIT_CYC ((`SDCI_MODE_LOAD_WAIT_NS*`SDCI_CLK_MHZ+999)/1000)
`define SDCI_ROW_ACTIVE_MIN_NS 48
`define SDCI_ROW_ACTIVE_MIN_CYC ((`SDCI_ROW_ACTIVE_MIN_NS*`SDCI_CLK_MHZ+999)/1000)
`define SDCI_REFRESH_CYCLE_NS 138
`define SDCI_REFRESH_CYCLE_CYC ((`SDCI_REFRESH_CYCLE_NS*`SDCI_CLK_MHZ+999)/1000)
`define SDCI_SELF_REFRESH_EXIT_NS 138
`define SDCI_SELF_REFRESH_EXIT_CYC ((`SDCI_SELF_REFRESH_EXIT_NS*`SDCI_CLK_MHZ+999)/1000)
`define SDCI_MASK_DELAY 2
`define SDCI_FIFO_DEPTH 4
`endif

// [rtl/sdci_fifo.v]
// small valid/ready fifo for read data
`timescale 1ns/1ps
`default_nettype none
module sdci_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire i_core_clk,
	input wire i_arst_n,
	input wire i_flush,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	wire push;
	wire pop;
	assign o_in_ready = (count_ff != DEPTH[AW:0]);
	assign o_out_valid = (count_ff != {(AW+1){1'b0}});
	assign o_out_data = mem[rd_ptr_ff];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	always @(posedge i_core_clk) begin
		if (push)
			mem[wr_ptr_ff] <= i_in_data;
	end
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
		end else if (i_flush) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
			if (push & ~pop)
				count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
			else if (pop & ~push)
				count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule // sdci_fifo

// [rtl/sdci_top.v]
// sdram command decoder, bank state, burst engine and data path
// How it works
// R1 - decode ras cas we into eight commands
// R2 - cke low with ras cas high we low: deep sleep
// R3 - chip select high registers no command
// R4 - no-op leaves running bursts alone
// R5 - activate opens a row per bank
// R6 - column from a0-a8, a10 auto precharge
// R7 - read mask high floats lane two clocks later
// R8 - write mask high blocks that byte now
// R9 - mask bit n governs byte lane n
// R10 - precharge a10 high closes every bank
// R11 - precharged bank waits before next activate
// R12 - auto precharge closes row after burst
// R13 - host waits precharge time after auto precharge
// R14 - burst terminate cuts latest burst
// R15 - host loads modes only when banks idle
// R16 - mode load: a0-a9 opcode, bank bits select
// R17 - refresh with cke low enters self refresh
// R18 - refresh row from internal counter
// R19 - host refreshes 8192 times per 64ms
// R20 - self refresh ignores all but cke
// R21 - host waits exit time after cke rises
// R22 - deep sleep loses array contents
// R23 - extended mode select is bank bits 10
// R24 - read data after cas latency 1..3
// R25 - host waits 200us and two refreshes; the host model waits only INIT_CYC = 40 cycles before them
// R26 - everything sampled on rising clock edge
`timescale 1ns/1ps
`default_nettype none
`include "sdci_defines.vh"
module sdci_top (
	input wire i_core_clk,
	input wire i_arst_n,
	input wire i_cke,
	input wire i_cs_n,
	input wire i_ras_n,
	input wire i_cas_n,
	input wire i_we_n,
	input wire [1:0] i_bank,
	input wire [`SDCI_ADDR_W-1:0] i_addr,
	input wire [3:0] i_dqm,
	input wire [`SDCI_DATA_W-1:0] i_dq,
	output reg [`SDCI_DATA_W-1:0] o_dq,
	output reg [3:0] o_dq_oe_n,
	output reg o_deep_sleep_mode,
	output reg o_self_refresh,
	output reg [`SDCI_ROW_W:0] o_refresh_row
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_READ = 4'b0010;
	localparam ST_WRITE = 4'b0100;
	localparam ST_SLEEP = 4'b1000;
	localparam MEM_W = 10;
	// pin synchronisers; commands are seen two cycles late, all together
	reg [21+`SDCI_ADDR_W+`SDCI_DATA_W-1:0] sync1_ff;
	reg [21+`SDCI_ADDR_W+`SDCI_DATA_W-1:0] sync2_ff;
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_ff <= {(21+`SDCI_ADDR_W+`SDCI_DATA_W){1'b1}};
			sync2_ff <= {(21+`SDCI_ADDR_W+`SDCI_DATA_W){1'b1}};
		end else begin
			sync1_ff <= {10'h000, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
				i_bank, i_dqm, i_addr, i_dq}; // R26
			sync2_ff <= sync1_ff;
		end
	end
	wire [`SDCI_DATA_W-1:0] s_dq = sync2_ff[`SDCI_DATA_W-1:0];
	wire [`SDCI_ADDR_W-1:0] s_addr =
		sync2_ff[`SDCI_DATA_W+`SDCI_ADDR_W-1:`SDCI_DATA_W];
	wire [3:0] s_dqm = sync2_ff[`SDCI_DATA_W+`SDCI_ADDR_W+3:
		`SDCI_DATA_W+`SDCI_ADDR_W];
	wire [1:0] s_bank = sync2_ff[`SDCI_DATA_W+`SDCI_ADDR_W+5:
		`SDCI_DATA_W+`SDCI_ADDR_W+4];
	wire [4:0] s_ctl = sync2_ff[`SDCI_DATA_W+`SDCI_ADDR_W+10:
		`SDCI_DATA_W+`SDCI_ADDR_W+6];
	wire s_cke = s_ctl[4];
	wire s_sel = ~s_ctl[3]; // R3
	wire [2:0] s_rcw = s_ctl[2:0];
	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	wire live = s_sel & (state_ff != ST_SLEEP); // R20
	wire is_act = live & s_cke & (s_rcw == 3'b011); // R1
	wire is_rd = live & s_cke & (s_rcw == 3'b101);
	wire is_wr = live & s_cke & (s_rcw == 3'b100);
	wire is_bt = live & s_cke & (s_rcw == 3'b110); // R1 R4
	wire is_pre = live & s_cke & (s_rcw == 3'b010);
	wire is_ref = live & (s_rcw == 3'b001);
	wire is_mrs = live & s_cke & (s_rcw == 3'b000);
	wire is_dpd = live & ~s_cke & (s_rcw == 3'b110); // R2
	reg [`SDCI_OPC_W-1:0] mode_ff;
	reg [`SDCI_OPC_W-1:0] ext_mode_ff;
	reg [2:0] mrd_ff;
	wire [31:0] mrd_full = `SDCI_MODE_LOAD_WAIT_CYC;
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_ff <= `SDCI_MODE_RST;
			ext_mode_ff <= `SDCI_EXT_RST;
			mrd_ff <= 3'h0;
		end else if (is_mrs) begin
			if (s_bank == `SDCI_BANK_EXT)
				ext_mode_ff <= s_addr[`SDCI_OPC_W-1:0]; // R16 R23
			else
				mode_ff <= s_addr[`SDCI_OPC_W-1:0]; // R16
			mrd_ff <= mrd_full[2:0];
		end else if (mrd_ff != 3'h0) begin
			mrd_ff <= mrd_ff - 3'h1;
		end
	end
	wire [1:0] cas_lat = mode_ff[`SDCI_CL_LSB+1:`SDCI_CL_LSB];
	wire [2:0] bl_code = mode_ff[`SDCI_BL_LSB+2:`SDCI_BL_LSB];
	wire full_page = (bl_code == 3'b111);
	wire single_wr = mode_ff[`SDCI_WBS_BIT];
	// burst length minus one, full page runs all 512 columns, wrapping round the row
	wire [8:0] bl_m1 = full_page ? 9'h1ff :
		(bl_code == 3'b011) ? 9'h007 :
		(bl_code == 3'b010) ? 9'h003 :
		(bl_code == 3'b001) ? 9'h001 : 9'h000;
	reg [1:0] bnk_ff;
	reg [8:0] col_ff;
	reg [8:0] left_ff;
	reg ap_ff;
	wire burst_end = (state_ff == ST_READ || state_ff == ST_WRITE) &
		(left_ff == 9'h000);
	wire ap_fire = burst_end & ap_ff & ~is_bt; // R12
	wire [3:0] bank_open;
	wire [3:0] bank_idle;
	wire [`SDCI_ROW_W*4-1:0] bank_row;
	wire flush = is_dpd;
	genvar g;
	generate
		for (g = 0; g < `SDCI_NBANK; g = g + 1) begin : g_bank
			wire [31:0] g_full = g;
			wire [1:0] bnk_id = g_full[1:0];
			wire pre_hit = (is_pre & (s_addr[`SDCI_A10] |
				(s_bank == bnk_id))) | (ap_fire & (bnk_ff == bnk_id)); // R10
			sdci_bank u_bank (
				.i_core_clk(i_core_clk),
				.i_arst_n(i_arst_n),
				.i_activate(is_act & (s_bank == bnk_id)),
				.i_row(s_addr[`SDCI_ROW_W-1:0]),
				.i_precharge(pre_hit),
				.i_flush(flush),
				.o_open(bank_open[g]),
				.o_idle(bank_idle[g]),
				.o_row(bank_row[g*`SDCI_ROW_W +: `SDCI_ROW_W])
			);
		end
	endgenerate
	wire acc_ok = bank_open[s_bank]; // R11
	wire start_rd = is_rd & acc_ok;
	wire start_wr = is_wr & acc_ok;
	// array kept small: bank, row bit 0 and column bits 6:0 index the words
	reg [`SDCI_DATA_W-1:0] mem [0:(1<<MEM_W)-1];
	wire [1:0] row_lo = bank_row[bnk_ff*`SDCI_ROW_W +: 2];
	wire [MEM_W-1:0] cur_idx = {bnk_ff, row_lo[0], col_ff[6:0]};
	wire [MEM_W-1:0] new_idx = {s_bank, bank_row[s_bank*`SDCI_ROW_W],
		s_addr[6:0]};
	// last burst cycle only closes the burst, it moves no word
	wire wr_now = start_wr | ((state_ff == ST_WRITE) & ~is_bt & ~start_rd &
		~burst_end);
	wire [MEM_W-1:0] wr_idx = start_wr ? new_idx : cur_idx;
	integer k;
	always @(posedge i_core_clk) begin
		for (k = 0; k < 4; k = k + 1) begin
			if (wr_now && !s_dqm[k]) // R8
				mem[wr_idx][k*8 +: 8] <= s_dq[k*8 +: 8]; // R9
		end
	end
	wire [MEM_W-1:0] rd_idx = start_rd ? new_idx : cur_idx;
	wire rd_now = start_rd | ((state_ff == ST_READ) & ~is_bt & ~start_wr &
		~burst_end);
	reg [`SDCI_DATA_W-1:0] rdata_ff;
	reg [2:0] rvalid_ff;
	// latency line: entry 0 is data available two cycles after command
	reg [`SDCI_DATA_W:0] lat_ff [0:2];
	reg [3:0] dqm1_ff;
	reg [3:0] dqm2_ff;
	always @(posedge i_core_clk) begin
		rdata_ff <= mem[rd_idx];
	end
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff <= ST_IDLE;
			bnk_ff <= 2'h0;
			col_ff <= 9'h000;
			left_ff <= 9'h000;
			ap_ff <= 1'b0;
			rvalid_ff <= 3'h0;
			dqm1_ff <= 4'hf;
			dqm2_ff <= 4'hf;
		end else begin
			state_ff <= nxt_state;
			rvalid_ff <= {rvalid_ff[1:0], rd_now};
			dqm1_ff <= s_dqm;
			dqm2_ff <= dqm1_ff; // R7
			if (start_rd || start_wr) begin
				bnk_ff <= s_bank;
				col_ff <= s_addr[8:0] + 9'h001; // R6
				left_ff <= (start_wr && single_wr) ? 9'h000 : bl_m1;
				ap_ff <= s_addr[`SDCI_A10] & ~full_page; // R6 R12
			end else if (state_ff == ST_READ || state_ff == ST_WRITE) begin
				col_ff <= col_ff + 9'h001;
				left_ff <= left_ff - 9'h001;
			end
		end
	end
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
		ST_IDLE, ST_READ, ST_WRITE: begin
			if (is_dpd)
				nxt_state = ST_SLEEP; // R2 R22
			else if (start_rd)
				nxt_state = ST_READ;
			else if (start_wr)
				nxt_state = ST_WRITE;
			else if (is_bt || burst_end)
				nxt_state = ST_IDLE; // R14
			else if (is_ref && !s_cke && (&bank_idle))
				nxt_state = ST_SLEEP; // R17
		end
		ST_SLEEP: begin
			if (s_cke)
				nxt_state = ST_IDLE;
		end
		default: nxt_state = ST_IDLE;
		endcase
	end
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lat_ff[0] <= {(`SDCI_DATA_W+1){1'b0}};
			lat_ff[1] <= {(`SDCI_DATA_W+1){1'b0}};
			lat_ff[2] <= {(`SDCI_DATA_W+1){1'b0}};
		end else begin
			lat_ff[0] <= {rvalid_ff[0], rdata_ff};
			lat_ff[1] <= lat_ff[0];
			lat_ff[2] <= lat_ff[1];
		end
	end
	// cas latency picks the tap; latency 0 code treated as 1
	reg [`SDCI_DATA_W:0] lat_tap;
	always @* begin
		case (cas_lat)
		2'b11: lat_tap = lat_ff[2]; // R24
		2'b10: lat_tap = lat_ff[1];
		default: lat_tap = lat_ff[0];
		endcase
	end
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [`SDCI_DATA_W+3:0] fifo_out_data;
	sdci_fifo #(
		.WIDTH(`SDCI_DATA_W+4),
		.DEPTH(`SDCI_FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_arst_n(i_arst_n),
		.i_flush(flush),
		.i_in_valid(lat_tap[`SDCI_DATA_W]),
		.o_in_ready(fifo_in_ready),
		.i_in_data({dqm2_ff, lat_tap[`SDCI_DATA_W-1:0]}),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(1'b1),
		.o_out_data(fifo_out_data)
	);
	// pins drain the fifo every cycle, so it never stalls the read path
	wire drop = lat_tap[`SDCI_DATA_W] & ~fifo_in_ready;
	reg [2:0] sr_cnt_ff;
	reg [`SDCI_ROW_W:0] ref_cnt_ff;
	reg [7:0] sr_div_ff;
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_dq <= {`SDCI_DATA_W{1'b0}};
			o_dq_oe_n <= 4'hf;
			o_deep_sleep_mode <= 1'b0;
			o_self_refresh <= 1'b0;
			o_refresh_row <= {(`SDCI_ROW_W+1){1'b0}};
			ref_cnt_ff <= {(`SDCI_ROW_W+1){1'b0}};
			sr_div_ff <= 8'h00;
			sr_cnt_ff <= 3'h0;
		end else begin
			o_dq <= fifo_out_data[`SDCI_DATA_W-1:0];
			o_dq_oe_n <= fifo_out_valid & ~drop ?
				fifo_out_data[`SDCI_DATA_W+3:`SDCI_DATA_W] : 4'hf; // R7 R9
			o_deep_sleep_mode <= (nxt_state == ST_SLEEP) &
				(o_deep_sleep_mode | is_dpd);
			o_self_refresh <= (nxt_state == ST_SLEEP) &
				~(o_deep_sleep_mode | is_dpd);
			sr_div_ff <= (state_ff == ST_SLEEP && !o_deep_sleep_mode) ?
				sr_div_ff + 8'h01 : 8'h00;
			if (is_ref && s_cke && (&bank_idle))
				ref_cnt_ff <= ref_cnt_ff + {{`SDCI_ROW_W{1'b0}}, 1'b1}; // R18
			else if (sr_div_ff == 8'hff)
				ref_cnt_ff <= ref_cnt_ff + {{`SDCI_ROW_W{1'b0}}, 1'b1}; // R20
			o_refresh_row <= ref_cnt_ff;
			if (sr_cnt_ff != 3'h0)
				sr_cnt_ff <= sr_cnt_ff - 3'h1;
		end
	end
endmodule // sdci_top
`default_nettype wire

// [testbench/sdci_host_model.sv]
// host controller model driving the sdram command pins
`timescale 1ns/1ps
`default_nettype none
`include "sdci_defines.vh"
module sdci_host_model #(
	parameter INIT_CYC = 40
) (
	input wire logic i_core_clk,
	output logic o_cke,
	output logic o_cs_n,
	output logic o_ras_n,
	output logic o_cas_n,
	output logic o_we_n,
	output logic [1:0] o_bank,
	output logic [`SDCI_ADDR_W-1:0] o_addr,
	output logic [3:0] o_dqm,
	output logic [`SDCI_DATA_W-1:0] o_dq
);
	initial begin
		{o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 5'b11111;
		o_bank = 2'b00;
		o_addr = '0;
		o_dqm = 4'h0;
		o_dq = '0;
	end
	// one command on a rising edge
	task drv(input logic [4:0] cc, input logic [1:0] b,
		input logic [12:0] a, input logic [3:0] m, input logic [31:0] d);
		begin
			@(posedge i_core_clk);
			{o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} <= cc;
			o_bank <= b;
			o_addr <= a;
			o_dqm <= m;
			o_dq <= d;
		end
	endtask
	// idle cycles; mask held so read lanes stay as asked
	task nop(input integer n, input logic cs);
		integer k;
		begin
			for (k = 0; k < n; k = k + 1) begin
				@(posedge i_core_clk);
				{o_cs_n, o_ras_n, o_cas_n, o_we_n} <= {cs, 3'b111};
				// released bus lines never keep their old value
				o_dq <= ~o_dq;
				o_addr <= ~o_addr;
				o_bank <= ~o_bank;
			end
		end
	endtask
	task cmd(input logic [4:0] cc, input logic [1:0] b,
		input logic [12:0] a, input logic [3:0] m, input logic [31:0] d);
		begin
			drv(cc, b, a, m, d);
			nop(1, 1'b0);
		end
	endtask
	task pre(input logic [1:0] b, input logic all);
		begin
			cmd(5'b10010, b, {2'b00, all, 10'h000}, 4'h0, 32'h0);
			nop(`SDCI_PRECHARGE_WAIT_CYC, 1'b0);
		end
	endtask
	// run is far shorter than one refresh period
	task aref;
		begin
			cmd(5'b10001, 2'b00, 13'h0, 4'h0, 32'h0);
			nop(`SDCI_REFRESH_CYCLE_CYC, 1'b0);
		end
	endtask
	task mrs(input logic [9:0] opc, input logic ext);
		begin
			cmd(5'b10000, ext ? 2'b10 : 2'b00, {3'b000, opc}, 4'h0, 32'h0);
			nop(`SDCI_MODE_LOAD_WAIT_CYC, 1'b0);
		end
	endtask
	task init;
		begin
			nop(INIT_CYC, 1'b1);
			pre(2'b00, 1'b1);
			aref;
			aref;
		end
	endtask
endmodule // sdci_host_model
`default_nettype wire

// [testbench/sdci_top_sva.sv]
// checker on the sdram command interface ports
`timescale 1ns/1ps
`default_nettype none
`include "sdci_defines.vh"
module sdci_top_sva (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_cke,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic [1:0] i_bank,
	input wire logic [`SDCI_ADDR_W-1:0] i_addr,
	input wire logic [3:0] i_dqm,
	input wire logic [`SDCI_DATA_W-1:0] i_dq,
	input wire logic [`SDCI_DATA_W-1:0] o_dq,
	input wire logic [3:0] o_dq_oe_n,
	input wire logic o_deep_sleep_mode,
	input wire logic o_self_refresh,
	input wire logic [`SDCI_ROW_W:0] o_refresh_row
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	wire sel = !i_cs_n;
	wire sref_cmd = !i_cke && sel && !i_ras_n && !i_cas_n && i_we_n;
	wire dsl_cmd = !i_cke && sel && i_ras_n && i_cas_n && !i_we_n;
	wire aref_cmd = i_cke && sel && !i_ras_n && !i_cas_n && i_we_n;
	wire bt_cmd = i_cke && sel && i_ras_n && i_cas_n && !i_we_n;
	property p_sref_in; sref_cmd |-> ##[1:6] o_self_refresh; endproperty
	a_sref_in: assert property (p_sref_in) else $error("no self refresh");
	property p_dsl_in; dsl_cmd |-> ##[1:6] o_deep_sleep_mode; endproperty
	a_dsl_in: assert property (p_dsl_in) else $error("no deep sleep");
	property p_dsl_off; o_deep_sleep_mode |-> o_dq_oe_n == 4'hf; endproperty
	a_dsl_off: assert property (p_dsl_off) else $error("drive in sleep");
	property p_sref_off; o_self_refresh |-> o_dq_oe_n == 4'hf; endproperty
	a_sref_off: assert property (p_sref_off) else $error("drive in sref");
	property p_sref_hold; o_self_refresh && !i_cke |=> o_self_refresh;
	endproperty
	a_sref_hold: assert property (p_sref_hold) else $error("sref left");
	property p_dsl_hold; o_deep_sleep_mode && !i_cke |=> o_deep_sleep_mode;
	endproperty
	a_dsl_hold: assert property (p_dsl_hold) else $error("sleep left");
	property p_ref_row; aref_cmd |-> ##[2:6] $changed(o_refresh_row);
	endproperty
	a_ref_row: assert property (p_ref_row) else $error("row stuck");
	property p_cs_gate; $rose(o_self_refresh) |-> $past(sel, 2) ||
		$past(sel, 3) || $past(sel, 4) || $past(sel, 5); endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("unselected");
	property p_bt; bt_cmd |-> ##[1:12] (o_dq_oe_n == 4'hf) [*8]; endproperty
	a_bt: assert property (p_bt) else $error("burst not cut");
endmodule // sdci_top_sva
bind sdci_top sdci_top_sva i_sdci_top_sva (.i_core_clk(i_core_clk),
	.i_arst_n(i_arst_n), .i_cke(i_cke), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n),
	.i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_bank(i_bank), .i_addr(i_addr),
	.i_dqm(i_dqm), .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
	.o_deep_sleep_mode(o_deep_sleep_mode), .o_self_refresh(o_self_refresh),
	.o_refresh_row(o_refresh_row));
`default_nettype wire

// [testbench/sdram_command_interface_tb_top.sv]
// self-checking bench for the sdram command interface
`timescale 1ns/1ps
`default_nettype none
`include "sdci_defines.vh"
module sdram_command_interface_tb_top;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	wire cke, cs_n, ras_n, cas_n, we_n, dsm, srf;
	wire [1:0] bank;
	wire [`SDCI_ADDR_W-1:0] addr;
	wire [3:0] dqm, oe_n;
	wire [`SDCI_DATA_W-1:0] wdq, rdq;
	wire [`SDCI_ROW_W:0] rrow;
	integer err_count = 0;
	integer n_checks = 0;
	integer seed = 32'h6353;
	integer cl, k, n;
	logic [31:0] mem [int];
	logic [3:0] rw0;
	logic [31:0] d;
	logic [1:0] b;
	logic [8:0] c;
	logic [3:0] m;
	always #2.5 core_clk = ~core_clk;
	sdci_top i_sdci_top (.i_core_clk(core_clk), .i_arst_n(arst_n),
		.i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
		.i_we_n(we_n), .i_bank(bank), .i_addr(addr), .i_dqm(dqm), .i_dq(wdq),
		.o_dq(rdq), .o_dq_oe_n(oe_n), .o_deep_sleep_mode(dsm),
		.o_self_refresh(srf), .o_refresh_row(rrow));
	sdci_host_model #(.INIT_CYC(40)) i_sdci_host_model (.i_core_clk(core_clk),
		.o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
		.o_we_n(we_n), .o_bank(bank), .o_addr(addr), .o_dqm(dqm), .o_dq(wdq));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task conclude;
		begin
			if (err_count == 0 && n_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// model follows the array's aliasing: row bit 0 and column bits 6:0
	function integer key(input logic [1:0] bk, input logic [8:0] cc);
		key = bk * 256 + rw0[bk] * 128 + cc[6:0];
	endfunction
	task act(input logic [1:0] bk, input logic [11:0] r);
		begin
			rw0[bk] = r[0];
			i_sdci_host_model.cmd(5'b10011, bk, {1'b0, r}, 4'h0, 32'h0);
		end
	endtask
	task wr(input logic [1:0] bk, input logic [8:0] cc, input logic ap,
		input logic [3:0] mk, input logic [31:0] dd);
		integer l;
		begin
			for (l = 0; l < 4; l = l + 1)
				if (!mk[l])
					mem[key(bk, cc)][8*l +: 8] = dd[8*l +: 8];
			i_sdci_host_model.cmd(5'b10100, bk, {2'b00, ap, 1'b0, cc}, mk, dd);
		end
	endtask
	task rd(input logic [1:0] bk, input logic [8:0] cc, input logic [3:0] mk,
		input logic ok);
		integer w;
		logic [31:0] lm;
		begin
			lm = {{8{~mk[3]}}, {8{~mk[2]}}, {8{~mk[1]}}, {8{~mk[0]}}};
			i_sdci_host_model.cmd(5'b10101, bk, {4'h0, cc}, mk, 32'h0);
			for (w = 0; w < 16 && oe_n === 4'hf; w = w + 1)
				@(negedge core_clk);
			if (ok) begin
				chk(oe_n, mk);
				chk(rdq & lm, mem[key(bk, cc)] & lm);
			end else
				chk(oe_n, 4'hf);
			i_sdci_host_model.nop(6, 1'b0);
		end
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		i_sdci_host_model.init;
		for (cl = 1; cl <= 3; cl = cl + 1) begin
			i_sdci_host_model.mrs({4'h0, cl[1:0], 4'h0}, 1'b0);
			d = $random(seed);
			b = d[1:0];
			c = d[22:14];
			m = (d[26:23] == 4'hf) ? 4'h5 : d[26:23];
			act(b, d[13:2]);
			act(b ^ 2'b01, d[31:20]);
			wr(b, c, 1'b0, 4'h0, $random(seed));
			wr(b ^ 2'b01, c, 1'b0, 4'h0, $random(seed));
			wr(b, c, 1'b0, m, $random(seed));
			rd(b, c, 4'h0, 1'b1);
			rd(b, c, m, 1'b1);
			// unselected write pattern must not reach the array
			i_sdci_host_model.drv(5'b11100, b, {4'h0, c}, 4'h0, ~d);
			rd(b, c, 4'h0, 1'b1);
			wr(b, c ^ 9'h1, 1'b1, 4'h0, $random(seed));
			i_sdci_host_model.nop(`SDCI_PRECHARGE_WAIT_CYC + 8, 1'b0);
			rd(b, c ^ 9'h1, 4'h0, 1'b0);
			act(b, d[13:2]);
			rd(b, c ^ 9'h1, 4'h0, 1'b1);
			i_sdci_host_model.pre(b, 1'b0);
			rd(b ^ 2'b01, c, 4'h0, 1'b1);
			rd(b, c, 4'h0, 1'b0);
			i_sdci_host_model.pre(b, 1'b1);
			rd(b ^ 2'b01, c, 4'h0, 1'b0);
		end
		i_sdci_host_model.mrs(10'h033, 1'b0);
		act(2'b00, 12'h000);
		i_sdci_host_model.drv(5'b10101, 2'b00, 13'h0, 4'h0, 32'h0);
		i_sdci_host_model.cmd(5'b10110, 2'b00, 13'h0, 4'h0, 32'h0);
		n = 0;
		for (k = 0; k < 24; k = k + 1) begin
			@(negedge core_clk);
			n = n + (oe_n !== 4'hf);
		end
		chk(n < 8, 1'b1);
		i_sdci_host_model.pre(2'b00, 1'b1);
		i_sdci_host_model.aref;
		i_sdci_host_model.drv(5'b00001, 2'b00, 13'h0, 4'h0, 32'h0);
		i_sdci_host_model.nop(`SDCI_ROW_ACTIVE_MIN_CYC + 4, 1'b1);
		@(negedge core_clk);
		chk(srf, 1'b1);
		i_sdci_host_model.drv(5'b10111, 2'b00, 13'h0, 4'h0, 32'h0);
		i_sdci_host_model.nop(`SDCI_SELF_REFRESH_EXIT_CYC, 1'b0);
		@(negedge core_clk);
		chk(srf, 1'b0);
		i_sdci_host_model.aref;
		i_sdci_host_model.drv(5'b00110, 2'b00, 13'h0, 4'h0, 32'h0);
		i_sdci_host_model.nop(20, 1'b1);
		@(negedge core_clk);
		chk(dsm, 1'b1);
		i_sdci_host_model.drv(5'b10111, 2'b00, 13'h0, 4'h0, 32'h0);
		i_sdci_host_model.nop(4, 1'b0);
		i_sdci_host_model.init;
		@(negedge core_clk);
		chk(dsm, 1'b0);
		conclude;
	end
	// whole sequence needs about a thousand cycles
	initial begin
		#100000;
		err_count = err_count + 1;
		conclude;
	end
endmodule // sdram_command_interface_tb_top
`default_nettype wire
